// ==== src/rx_buffer_consts.svh ====
/*
 Constants of the receive buffer and status block: register offsets, field
 positions, reset values. Assumes inclusion by bare name from src/.
*/
`ifndef RX_BUFFER_CONSTS_SVH
`define RX_BUFFER_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_SERIAL_DATA      4'h0
`define OFS_SERIAL_STATUS    4'h1
`define OFS_SERIAL_CONTROL   4'h2
`define OFS_FRAME_FORMAT     4'h3
`define OFS_FRAME_INJECT_LO  4'h4
`define OFS_FRAME_INJECT_HI  4'h5

// ****************************************
// Status register fields
// ****************************************
`define STS_RXC_BIT          7
`define STS_FE_BIT           4
`define STS_DOR_BIT          3
`define STS_PE_BIT           2

// ****************************************
// Control register fields
// ****************************************
`define CTL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT        7
`define CTL_RECEIVER_ENABLE_BIT         4
`define CTL_SIZE2_BIT        2
`define CTL_RX9_BIT          1
`define CTL_TX9_BIT          0

// ****************************************
// Frame format register fields
// ****************************************
`define FMT_PAR_EN_BIT       5
`define FMT_PAR_ODD_BIT      4
`define FMT_STOP2_BIT        3
`define FMT_SIZE_HI          2
`define FMT_SIZE_LO          1

// ****************************************
// Reset values, nine-bit size code and depth
// ****************************************
`define CONTROL_RESET        8'h00
`define FORMAT_RESET         8'h06
`define SIZE_NINE_BIT        3'h7
`define FIFO_DEPTH           2

`endif

// ==== src/rx_buffer_pkg.sv ====
/*
 Types shared by the receive buffer modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rx_buffer_pkg;

   typedef struct packed {
      logic [8:0] data;
      logic       frame_error;
      logic       overrun;
      logic       parity_error;
   } rx_entry_t;

   typedef enum logic [1:0] {
      ST_DISABLED = 2'h0,
      ST_IDLE     = 2'h1,
      ST_RECEIVE  = 2'h3
   } rx_state_t;

endpackage : rx_buffer_pkg

// ==== src/rx_entry_if.sv ====
/*
 Carries a completed frame from the frame checker into the FIFO.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
interface rx_entry_if;
   logic                   push;
   rx_buffer_pkg::rx_entry_t entry;

   modport source (output push, output entry);
   modport sink   (input push, input entry);
endinterface : rx_entry_if

// ==== src/rx_frame_check.sv ====
/*
 Frame checker: converts a shifted frame into a buffer entry with masked
 data, frame and parity error flags. Assumes frame fields stable at done.
*/
`timescale 1ns/100ps
module rx_frame_check
(
   input  wire logic [8:0] frame_data,
   input  wire logic       frame_parity,
   input  wire logic       first_stop,
   input  wire logic       frame_done,
   input  wire logic       overrun,
   input  wire logic [2:0] size_code,
   input  wire logic       parity_enable,
   input  wire logic       parity_odd,
   rx_entry_if.source      out
);
   logic [8:0] mask;
   logic [8:0] data_masked;
   logic       computed;

   // ****************************************
   // Masking and checks
   // ****************************************
   always_comb
   begin
      case (size_code)
         3'h0:    mask = 9'h01F;
         3'h1:    mask = 9'h03F;
         3'h2:    mask = 9'h07F;
         3'h7:    mask = 9'h1FF;
         default: mask = 9'h0FF;
      endcase
   end

   assign data_masked = frame_data & mask;
   assign computed = (^data_masked) ^ parity_odd;

   assign out.push = frame_done;
   assign out.entry.data = data_masked;
   assign out.entry.frame_error = ~first_stop;
   assign out.entry.overrun = overrun;
   // Only flagged when checking is on as the frame enters the FIFO
   assign out.entry.parity_error =
      parity_enable & (computed != frame_parity);
endmodule : rx_frame_check

// ==== src/rx_fifo.sv ====
/*
 Two-entry receive FIFO holding character and per-character flags.
 Assumes push only when not full or when the head is popped alongside.
*/
`timescale 1ns/100ps
`include "rx_buffer_consts.svh"
module rx_fifo
(
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     flush,
   input  wire logic                     pop,
   rx_entry_if.sink                      in,
   output rx_buffer_pkg::rx_entry_t      head,
   output logic                          count_nonzero,
   output logic                          full
);
   typedef struct packed {
      rx_buffer_pkg::rx_entry_t [1:0] mem;
      logic [1:0]                    count;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;
   logic        do_pop;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_st = st;
      do_pop = pop && (st.count != 2'h0);
      if (do_pop)
      begin
         next_st.mem[0] = st.mem[1];
         next_st.count = st.count - 2'h1;
      end
      if (in.push && (next_st.count < 2'(`FIFO_DEPTH)))
      begin
         next_st.mem[next_st.count[0]] = in.entry;
         next_st.count = next_st.count + 2'h1;
      end
      if (flush)
         next_st.count = 2'h0;
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign head = st.mem[0];
   assign count_nonzero = st.count != 2'h0;
   assign full = st.count == 2'(`FIFO_DEPTH);
endmodule : rx_fifo

// ==== src/serial_receive_buffer_status.sv ====
/*
 Receive buffer and status block of a serial port: register file, receive
 pin capture, frame collection, two-entry FIFO, receive-complete interrupt.
 Assumes a sample strobe from an external bit-timing unit; start detection
 and bit voting happen outside and arrive as bit_valid/start_detect pulses.
*/
// Operation
// - Data read advances FIFO to next entry
// - Receive-complete set while buffer holds data
// - Receiver disable flushes the buffer
// - Interrupt held while flag and enable set
// - Error flags stored with their character
// - Status writes leave error flags unchanged
// - Error flags raise no interrupt
// - Frame error is inverted first stop
// - Only first stop bit is checked
// - Overrun on start with full buffer
// - Overrun clears on successful transfer
// - Parity flag zero when checking disabled
// - Parity enable and odd/even select
// - Parity flag only on mismatch when enabled
// - Disable aborts reception, frees pin
// - First stop bit transfers frame
// - Unused upper data bits read zero
`timescale 1ns/100ps
`include "rx_buffer_consts.svh"
module serial_receive_buffer_status
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [3:0] address,
   input  wire logic [7:0] write_data,
   input  wire logic       write_strobe,
   input  wire logic       read_strobe,
   output logic      [7:0] read_data,
   input  wire logic       global_irq_enable,
   input  wire logic       receive_pin,
   input  wire logic       start_detect,
   input  wire logic       bit_valid,
   output logic            receive_complete_irq,
   output logic            receive_pin_override,
   output logic            receive_bit
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0]                control;
      logic [7:0]                format;
      rx_buffer_pkg::rx_state_t  fsm;
      logic [3:0]                bit_index;
      logic [8:0]                shift;
      logic                      parity_bit;
      logic                      stop_bit;
      logic                      frame_done;
      logic                      pending;
      logic [8:0]                pending_data;
      logic                      pending_parity;
      logic                      pending_stop;
      logic                      overrun;
      logic [1:0]                pin_sync;
      logic [7:0]                read_data;
      logic                      irq;
      logic                      pin_override;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;

   rx_entry_if               entry_bus ();
   rx_buffer_pkg::rx_entry_t head;
   logic                     fifo_nonempty;
   logic                     fifo_full;
   logic                     data_read;
   logic                     flush;
   logic [2:0]               size_code;
   logic [3:0]               data_bits;
   logic                     par_en;
   logic                     transfer;
   logic [7:0]               status_view;

   // Head entry as software sees it
   logic                     head_frame_error;
   logic                     head_overrun;
   logic                     head_parity_error;
   logic                     head_ninth;
   logic [7:0]               head_byte;

   // Receive slot decode and interrupt terms
   logic                     line_bit;
   logic                     data_slot;
   logic                     parity_slot;
   logic                     next_nonempty;
   logic                     irq_allowed;

   assign size_code = {st.control[`CTL_SIZE2_BIT],
                       st.format[`FMT_SIZE_HI:`FMT_SIZE_LO]};
   assign par_en = st.format[`FMT_PAR_EN_BIT];
   assign data_read = read_strobe && (address == `OFS_SERIAL_DATA);
   // Disable takes effect at once, no draining
   assign flush = ~st.control[`CTL_RECEIVER_ENABLE_BIT];
   // Pending frame moves in whenever a slot frees up
   assign transfer = st.frame_done && (!fifo_full || data_read);

   always_comb
   begin
      case (size_code)
         3'h0:    data_bits = 4'h5;
         3'h1:    data_bits = 4'h6;
         3'h2:    data_bits = 4'h7;
         3'h7:    data_bits = 4'h9;
         default: data_bits = 4'h8;
      endcase
   end

   // ****************************************
   // Frame layout
   // ****************************************
   // Only the second synchroniser flop feeds logic
   assign line_bit = st.pin_sync[1];
   assign data_slot = st.bit_index < data_bits;
   // Parity slot exists only while checking is on
   assign parity_slot = par_en && (st.bit_index == data_bits);

   // ****************************************
   // Frame checker and FIFO
   // ****************************************
   rx_frame_check u_check
   (
      .frame_data    (st.pending_data),
      .frame_parity  (st.pending_parity),
      .first_stop    (st.pending_stop),
      .frame_done    (transfer),
      .overrun       (st.overrun),
      .size_code     (size_code),
      .parity_enable (par_en),
      .parity_odd    (st.format[`FMT_PAR_ODD_BIT]),
      .out           (entry_bus.source)
   );

   rx_fifo u_fifo
   (
      .core_clk      (core_clk),
      .reset         (reset),
      .flush         (flush),
      .pop           (data_read),
      .in            (entry_bus.sink),
      .head          (head),
      .count_nonzero (fifo_nonempty),
      .full          (fifo_full)
   );

   // ****************************************
   // Head view
   // ****************************************
   // An empty buffer shows neither stale flags nor stale data
   assign head_frame_error = fifo_nonempty & head.frame_error;
   assign head_overrun = fifo_nonempty & head.overrun;
   assign head_parity_error = fifo_nonempty & head.parity_error;
   assign head_ninth = fifo_nonempty & head.data[8];
   assign head_byte = fifo_nonempty ? head.data[7:0] : 8'h00;

   // Error flags come from the FIFO head only; write_data never reaches them
   assign status_view = {fifo_nonempty, 2'h0, head_frame_error,
                         head_overrun, head_parity_error,
                         2'h0};

   // ****************************************
   // Interrupt terms
   // ****************************************
   // Flag value after this edge: popping one of two keeps it set
   assign next_nonempty = transfer
                          || fifo_full
                          || (fifo_nonempty && !data_read);
   assign irq_allowed = st.control[`CTL_RECEIVE_COMPLETE_IRQ_ENABLE_BIT]
                        && st.control[`CTL_RECEIVER_ENABLE_BIT]
                        && global_irq_enable;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_st = st;
      next_st.pin_sync = {st.pin_sync[0], receive_pin};
      next_st.read_data = 8'h00;

      // Register writes
      if (write_strobe)
      begin
         case (address)
            `OFS_SERIAL_CONTROL:
               next_st.control = {write_data[7:2], st.control[1],
                                  write_data[0]};
            `OFS_FRAME_FORMAT:  next_st.format = write_data;
            default:            next_st.control = next_st.control;
         endcase
      end

      // Register reads, data one cycle later
      if (read_strobe)
      begin
         case (address)
            `OFS_SERIAL_DATA:    next_st.read_data = head_byte;
            `OFS_SERIAL_STATUS:  next_st.read_data = status_view;
            `OFS_SERIAL_CONTROL:
               next_st.read_data = {st.control[7:2], head_ninth,
                                    st.control[0]};
            `OFS_FRAME_FORMAT:   next_st.read_data = st.format;
            default:             next_st.read_data = 8'h00;
         endcase
      end

      // Completed frame held until the buffer accepts it
      if (transfer)
      begin
         next_st.frame_done = 1'b0;
         next_st.overrun = 1'b0;
      end

      // Reception
      case (st.fsm)
         rx_buffer_pkg::ST_DISABLED:
         begin
            if (st.control[`CTL_RECEIVER_ENABLE_BIT])
               next_st.fsm = rx_buffer_pkg::ST_IDLE;
         end
         rx_buffer_pkg::ST_IDLE:
         begin
            if (start_detect)
            begin
               // New start while full and a frame still waits
               if (st.frame_done && !transfer)
                  next_st.overrun = 1'b1;
               next_st.fsm = rx_buffer_pkg::ST_RECEIVE;
               next_st.bit_index = 4'h0;
               next_st.shift = 9'h000;
            end
         end
         rx_buffer_pkg::ST_RECEIVE:
         begin
            if (bit_valid)
            begin
               if (data_slot)
                  next_st.shift[st.bit_index] = line_bit;
               else if (parity_slot)
                  next_st.parity_bit = line_bit;
               else
               begin
                  // First stop bit ends the frame; later ones ignored
                  next_st.stop_bit = line_bit;
                  next_st.frame_done = 1'b1;
                  next_st.pending_data = st.shift;
                  next_st.pending_parity = st.parity_bit;
                  next_st.pending_stop = line_bit;
                  next_st.fsm = rx_buffer_pkg::ST_IDLE;
               end
               next_st.bit_index = st.bit_index + 4'h1;
            end
         end
         default: next_st.fsm = rx_buffer_pkg::ST_DISABLED;
      endcase

      // Disable abandons everything in flight
      if (!next_st.control[`CTL_RECEIVER_ENABLE_BIT])
      begin
         next_st.fsm = rx_buffer_pkg::ST_DISABLED;
         next_st.frame_done = 1'b0;
         next_st.overrun = 1'b0;
      end

      next_st.pin_override = next_st.control[`CTL_RECEIVER_ENABLE_BIT];
      next_st.irq = next_nonempty && irq_allowed;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st <= '0;
         st.control <= `CONTROL_RESET;
         st.format <= `FORMAT_RESET;
         st.fsm <= rx_buffer_pkg::ST_DISABLED;
         st.pin_sync <= 2'b11;
      end
      else
         st <= next_st;
   end

   assign read_data = st.read_data;
   assign receive_complete_irq = st.irq;
   assign receive_pin_override = st.pin_override;
   assign receive_bit = st.stop_bit;
endmodule : serial_receive_buffer_status

// ==== test/rx_status_asserts.sv ====
/*
 Port checker of the receive buffer block.
 Assumes the bind below and a single clock domain.
*/
`timescale 1ns/100ps
module rx_status_checker
(
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic [3:0] address,
   input wire logic [7:0] write_data,
   input wire logic       write_strobe,
   input wire logic       read_strobe,
   input wire logic [7:0] read_data,
   input wire logic       global_irq_enable,
   input wire logic       receive_complete_irq,
   input wire logic       receive_pin_override
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // ****************************************
   // Port relations
   // ****************************************
   rdata_idle_a:
      assert property (!$past(read_strobe) |-> read_data == 8'h00)
      else $error("read data not idle");
   unmapped_zero_a:
      assert property ($past(read_strobe && address > 4'h5)
                       |-> read_data == 8'h00)
      else $error("unmapped read not zero");
   pin_override_a:
      assert property (write_strobe && address == 4'h2
                       |=> receive_pin_override == $past(write_data[4]))
      else $error("pin override wrong");
   irq_global_a:
      assert property (receive_complete_irq |-> $past(global_irq_enable))
      else $error("irq without global enable");
   irq_rx_on_a:
      assert property (receive_complete_irq |-> $past(receive_pin_override))
      else $error("irq with receiver off");
   disable_irq_a:
      assert property (write_strobe && address == 4'h2 && !write_data[4]
                       |-> ##2 (!receive_complete_irq) [*3])
      else $error("irq after disable");
   irq_mask_a:
      assert property (write_strobe && address == 4'h2 && !write_data[7]
                       |-> ##2 !receive_complete_irq)
      else $error("irq while masked");
   rxc_off_a:
      assert property ($past(read_strobe && address == 4'h1)
                       && $past(!receive_pin_override, 3)
                       |-> {read_data[7], read_data[4:2]} == 4'h0)
      else $error("status not flushed");
   cover property ($rose(receive_complete_irq));
   cover property ($past(read_strobe && address == 4'h1) && read_data[3]);
   cover property ($past(read_strobe && address == 4'h1) && read_data[4]);
endmodule : rx_status_checker

bind serial_receive_buffer_status rx_status_checker i_rx_status_checker
(
   .core_clk(core_clk), .reset(reset), .address(address),
   .write_data(write_data), .write_strobe(write_strobe),
   .read_strobe(read_strobe), .read_data(read_data),
   .global_irq_enable(global_irq_enable),
   .receive_complete_irq(receive_complete_irq),
   .receive_pin_override(receive_pin_override)
);

// ==== test/remote_serial_tx.sv ====
/*
 Far-side transmitter with its start and voted-bit pulses.
 Assumes calls right after a rising clock edge.
*/
`timescale 1ns/100ps
module remote_serial_tx
(
   input  wire logic core_clk,
   output logic      receive_pin,
   output logic      start_detect,
   output logic      bit_valid
);
   initial
   begin
      receive_pin  = 1'b1;
      start_detect = 1'b0;
      bit_valid    = 1'b0;
   end

   // ****************************************
   // Frame sender, bits LSB first, then first stop
   // ****************************************
   task automatic send(input logic [10:0] w, input int n, input logic stop);
      start_detect <= 1'b1;
      receive_pin  <= 1'b0;
      for (int i = 0; i <= n; i++)
      begin
         @(posedge core_clk);
         start_detect <= 1'b0;
         receive_pin  <= (i == n) ? stop : w[i];
         // Pin settles through the synchroniser first
         repeat (4) @(posedge core_clk);
         bit_valid <= 1'b1;
         @(posedge core_clk);
         bit_valid <= 1'b0;
      end
      receive_pin <= ~stop;
      repeat (3) @(posedge core_clk);
      receive_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask : send
endmodule : remote_serial_tx

// ==== test/serial_receive_buffer_status_tb_top.sv ====
/*
 Self-checking bench of the receive buffer block with a queue model.
 Assumes the checker bind and the far-side transmitter model.
*/
`timescale 1ns/100ps
module serial_receive_buffer_status_tb_top;
   logic       core_clk, reset, write_strobe, read_strobe;
   logic       global_irq_enable, receive_pin, start_detect, bit_valid;
   logic       receive_complete_irq, receive_pin_override, receive_bit;
   logic [3:0] address;
   logic [7:0] write_data, read_data, v;
   logic       pen, podd;
   int         errors, cmp_count, nbits, k;
   int         exp_q[$];

   serial_receive_buffer_status i_serial_receive_buffer_status
   (
      .core_clk(core_clk), .reset(reset), .address(address),
      .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data),
      .global_irq_enable(global_irq_enable), .receive_pin(receive_pin),
      .start_detect(start_detect), .bit_valid(bit_valid),
      .receive_complete_irq(receive_complete_irq),
      .receive_pin_override(receive_pin_override),
      .receive_bit(receive_bit)
   );
   remote_serial_tx i_remote_serial_tx
   (
      .core_clk(core_clk), .receive_pin(receive_pin),
      .start_detect(start_detect), .bit_valid(bit_valid)
   );

   always #10 core_clk = ~core_clk;
   initial
   begin
      #1_000_000;
      errors++;
      conclude();
   end

   // ****************************************
   // Bus, model and check tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      address      <= a;
      write_data   <= d;
      write_strobe <= 1'b1;
      @(posedge core_clk);
      write_strobe <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      address     <= a;
      read_strobe <= 1'b1;
      @(posedge core_clk);
      read_strobe <= 1'b0;
      @(negedge core_clk);
      v = read_data;
      @(posedge core_clk);
   endtask : rd
   task automatic rdc(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
      rd(a);
      chk(v & m, e);
   endtask : rdc
   task automatic look_irq(input logic e);
      repeat (2) @(negedge core_clk);
      chk(receive_complete_irq, e);
      @(posedge core_clk);
   endtask : look_irq
   // Size index 4 means nine-bit characters
   task automatic cfg(input int s, input logic [2:0] f, input logic ie);
      logic [2:0] c;
      c     = (s == 4) ? 3'h7 : 3'(s);
      nbits = (s == 4) ? 9 : 5 + s;
      pen   = f[2];
      podd  = f[1];
      wr(4'h3, {2'h0, f, c[1:0], 1'b0});
      wr(4'h2, {ie, 2'h0, 1'b1, 1'b0, c[2], 2'h0});
   endtask : cfg
   task automatic frame(input logic [8:0] d, input logic bad,
                        input logic stop);
      logic p;
      d = d & 9'((1 << nbits) - 1);
      p = ^d ^ podd ^ bad;
      i_remote_serial_tx.send(11'(d) | 11'(p) << nbits, nbits + int'(pen),
                              stop);
      chk(receive_bit, stop);
      if (exp_q.size() < 2)
         exp_q.push_back(int'({~stop, 1'b0, pen & bad, d}));
   endtask : frame
   task automatic take();
      logic [7:0] s;
      logic [7:0] c;
      int         e;
      e = exp_q.pop_front();
      rd(4'h1);
      s = v;
      rd(4'h2);
      c = v;
      rd(4'h0);
      if (nbits < 9)
         c[1] = e[8];
      chk(s[7], 1'b1);
      chk(s[4:2], e[11:9]);
      chk({c[1], v}, e[8:0]);
   endtask : take
   task automatic conclude();
      if (errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   initial
   begin
      core_clk          = 1'b0;
      reset             = 1'b1;
      address           = 4'h0;
      write_data        = 8'h00;
      write_strobe      = 1'b0;
      read_strobe       = 1'b0;
      global_irq_enable = 1'b0;
      void'($urandom(40473));
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rdc(4'h3, 8'hFF, 8'h06);
      rdc(4'h1, 8'hFF, 8'h00);
      rdc(4'hF, 8'hFF, 8'h00);
      global_irq_enable <= 1'b1;
      repeat (20)
      begin
         cfg($urandom_range(4), 3'($urandom), 1'b1);
         repeat (1 + $urandom_range(1))
            frame(9'($urandom), 1'($urandom), 1'($urandom));
         look_irq(1'b1);
         wr(4'h1, 8'hE3);
         while (exp_q.size() > 0)
            take();
         rdc(4'h1, 8'h80, 8'h00);
         look_irq(1'b0);
      end
      cfg(3, 3'h4, 1'b0);
      frame(9'h155, 1'b1, 1'b0);
      look_irq(1'b0);
      cfg(3, 3'h4, 1'b1);
      global_irq_enable <= 1'b0;
      look_irq(1'b0);
      global_irq_enable <= 1'b1;
      look_irq(1'b1);
      take();
      cfg(3, 3'h0, 1'b1);
      for (k = 1; k < 5; k++)
         i_remote_serial_tx.send(11'(k), 8, 1'b1);
      rdc(4'h1, 8'h88, 8'h80);
      rdc(4'h0, 8'hFF, 8'h01);
      rdc(4'h1, 8'h88, 8'h80);
      rdc(4'h0, 8'hFF, 8'h02);
      rdc(4'h1, 8'h88, 8'h88);
      for (k = 0; k < 4 && v[7] === 1'b1; k++)
      begin
         rd(4'h0);
         rd(4'h1);
      end
      chk(v[7], 1'b0);
      if (k == 4)
         conclude();
      frame(9'h03C, 1'b0, 1'b1);
      take();
      frame(9'h0AA, 1'b0, 1'b1);
      frame(9'h011, 1'b0, 1'b1);
      wr(4'h2, 8'h80);
      look_irq(1'b0);
      rdc(4'h1, 8'h9C, 8'h00);
      exp_q.delete();
      cfg(3, 3'h0, 1'b1);
      fork
         i_remote_serial_tx.send(11'h0F0, 8, 1'b1);
         begin
            repeat (20) @(posedge core_clk);
            wr(4'h2, 8'h80);
         end
      join
      cfg(3, 3'h0, 1'b1);
      rdc(4'h1, 8'h80, 8'h00);
      frame(9'h096, 1'b0, 1'b1);
      take();
      conclude();
   end
endmodule : serial_receive_buffer_status_tb_top
